// ---- ulp_cfg.svh ----
/*
  Offsets, field positions, reset values and timing figures of the PHY
  side of the low pin link port. Included by the divider, port, register array and bench files.
*/
`ifndef ULP_CFG_SVH
`define ULP_CFG_SVH

// Link command kinds in bits 7:6
`define ULP_CMD_SPECIAL 2'h0
`define ULP_CMD_TX      2'h1
`define ULP_CMD_REGWR   2'h2
`define ULP_CMD_REGRD   2'h3

// Register addresses (6 bit)
`define ULP_AD_ID_END   6'h04
`define ULP_AD_FUNC     6'h04
`define ULP_AD_IFACE    6'h07
`define ULP_AD_OTG      6'h0A
`define ULP_AD_IER      6'h0D
`define ULP_AD_IEF      6'h10
`define ULP_AD_STAT     6'h13
`define ULP_AD_LATCH    6'h14
`define ULP_AD_DEBUG    6'h15
`define ULP_AD_SCRATCH  6'h16
`define ULP_ALIAS_CNT   6'h03

// Power-on values
`define ULP_RST_FUNC    8'h41
`define ULP_RST_IFACE   8'h00
`define ULP_RST_OTG     8'h06
`define ULP_RST_IER     8'h1F
`define ULP_RST_IEF     8'h1F
`define ULP_RST_SCRATCH 8'h00

// Writable bits (reserved bits read low)
`define ULP_KEEP_FUNC   8'h7F
`define ULP_KEEP_IFACE  8'hFB
`define ULP_KEEP_ALL    8'hFF

// Function control fields
`define ULP_FUNC_XRST   5
`define ULP_FUNC_SUSPM  6

// Receive command with receive-active event, low power interrupt bit
`define ULP_RXCMD_ACT   8'h10
`define ULP_LP_INT_BIT  3

// Link clock: nominal rate and half period in ref_clk cycles
`define ULP_LINK_MHZ    60
`define ULP_CLK_HALF    2

// Receive-end delay in high-speed bit clocks
`define ULP_RX_END_MAX  43
`define ULP_RX_END_LIM  63

`endif

// ---- ulp_clk_div.sv ----
/*
  Divider that makes the link clock from ref_clk and marks each rising
  edge with a one-cycle pulse. Assumes run is a level on ref_clk.
*/
`timescale 1ns/1ns
`include "ulp_cfg.svh"

module ulp_clk_div
  import ulp_pkg::*;
#(
  parameter int HALF = `ULP_CLK_HALF
)(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  // Link clock and its rising-edge pulse
  output logic      phy_clock_output,
  output logic      riseTick
);

  logic [7:0] cnt_ff;
  logic       clk_ff;
  logic       tick_ff;

  wire logic flip = run && (cnt_ff == 8'(HALF - 1));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff  <= 8'h00;
      clk_ff  <= 1'b0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= (!run || flip) ? 8'h00 : cnt_ff + 8'h01;
      clk_ff  <= run && (clk_ff ^ flip);
      tick_ff <= flip && !clk_ff;
    end
  end

  assign phy_clock_output   = clk_ff;
  assign riseTick = tick_ff;

endmodule

// ---- ulp_link_model.sv ----
/* Behavioural link controller on the far side of the PHY port bus.
   Assumes the PHY makes the link clock and updates its outputs after its edges. */
`timescale 1ns/1ns
module ulp_link_model (
  // Clocks
  input  wire logic       ref_clk,
  input  wire logic       lclk,
  // PHY outputs
  input  wire logic       dir,
  input  wire logic       nxt,
  input  wire logic [7:0] phyData,
  input  wire logic       phyOe,
  // Link drive and resolved bus
  output logic            stopOut = 1'b0,
  output logic [7:0]      bus
);
  logic       dirQ   = 1'b1;
  logic       ownBus = 1'b0;
  logic       letGo  = 1'b0;
  logic [7:0] lData  = 8'h00;
  logic [7:0] got[$];
  int         n;
  // Idle drive is 00; an undriven bus shows the inverse of the last byte
  assign bus = phyOe ? phyData : (ownBus && !letGo && !dir) ? lData : ~lData;
  always @(posedge lclk)
  begin
    dirQ   <= dir;
    // Drive from the cycle after the turn-around
    ownBus <= !dir;
    if (dir && dirQ)
      got.push_back(bus);
  end
  task automatic tick();
    @(posedge lclk);
    @(negedge ref_clk);
  endtask
  task automatic own();
    n = 0;
    while (!ownBus && n++ < 60)
      tick();
  endtask
  // Hold each byte until the PHY takes it
  task automatic put(input logic [7:0] b);
    lData = b;
    n     = 0;
    tick();
    while (!nxt && n++ < 20)
      tick();
  endtask
  task automatic send(input logic [7:0] q[$]);
    own();
    foreach (q[i])
      put(q[i]);
    lData   = 8'h00;
    stopOut = 1'b1;
    tick();
    stopOut = 1'b0;
    tick();
  endtask
  task automatic read(input logic [5:0] a, output logic [7:0] v);
    own();
    got.delete();
    put({2'h3, a});
    letGo = 1'b1;
    lData = 8'h00;
    n     = 0;
    while (got.size() == 0 && n++ < 20)
      tick();
    v     = (got.size() != 0) ? got.pop_front() : 8'hXX;
    letGo = 1'b0;
  endtask
  task automatic wake();
    stopOut = 1'b1;
    n       = 0;
    while (phyOe && n++ < 200)
      @(negedge ref_clk);
    stopOut = 1'b0;
  endtask
endmodule

// ---- ulp_phy_port.sv ----
/*
  PHY side of an 8-bit single data rate low pin link port: makes the link
  clock, arbitrates the data bus with the direction output, paces bytes
  with the next output, routes commands to the transmitter or registers,
  returns receive data and signals line state while in low power.
  Assumes link pins arrive unsynchronised; user-side signals are on ref_clk.
*/
`timescale 1ns/1ns
`include "ulp_cfg.svh"

module ulp_phy_port
  import ulp_pkg::*;
#(
  parameter int CLK_HALF = `ULP_CLK_HALF
)(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Link pins
  output logic            phyClockOutput,
  output logic            busDir,
  output logic            busNext,
  input  wire logic       busStopIn,
  input  wire logic [7:0] busDataIn,
  output logic [7:0]      busDataOut,
  output logic            busDataOe,
  // Transmit stream toward the USB transmitter
  output logic [7:0]      txData,
  output logic            txValid,
  output logic            txLast,
  input  wire logic       txReady,
  // Receive stream from the USB receiver
  input  wire logic       rxActive,
  input  wire logic       rxValid,
  input  wire logic [7:0] rxData,
  output logic            rxTake,
  // Analog status
  input  wire logic       pllLocked,
  input  wire logic [1:0] lineState,
  input  wire logic [4:0] otgSense,
  // Register fields toward the transceiver
  output logic [7:0]      funcCtl,
  output logic [7:0]      ifaceCtl,
  output logic [7:0]      otgCtl,
  output logic            xcvrReset
);

  // Receive-end budget in ref_clk cycles, eight bit clocks per link cycle
  localparam int RX_END_BUDGET = `ULP_RX_END_MAX / 8 * 2 * CLK_HALF;

  ulp_state_type state_ff;
  ulp_state_type nxt_state;
  ulp_pins_type  pinsMeta_ff;
  ulp_pins_type  pinsSync_ff;
  ulp_regop_type nxt_op;
  ulp_regop_type op_ff;
  logic          busDir_ff;
  logic          nxt_dir;
  logic          busNext_ff;
  logic          nxt_next;
  logic [7:0]    busDataOut_ff;
  logic [7:0]    nxt_dout;
  logic          busDataOe_ff;
  logic          nxt_oe;
  logic [7:0]    txData_ff;
  logic [7:0]    nxt_txData;
  logic          txValid_ff;
  logic          nxt_txValid;
  logic          txLast_ff;
  logic          nxt_txLast;
  logic          rxTake_ff;
  logic          nxt_rxTake;
  logic [5:0]    addr_ff;
  logic [5:0]    nxt_addr;
  logic [7:0]    wdata_ff;
  logic [7:0]    nxt_wdata;
  logic          lpInt_ff;
  logic [4:0]    otgPrev_ff;
  logic          suspSet;
  logic          linkTick;
  logic          linkClk;
  logic [7:0]    rdData;

  // Synchronised link pins and analog levels
  wire logic        stpS   = pinsSync_ff.stop;
  wire logic [7:0]  dinS   = pinsSync_ff.data;
  wire logic [1:0]  lsS    = pinsSync_ff.line;
  wire logic [4:0]  otgS   = pinsSync_ff.otg;
  wire ulp_cmd_type cmd    = ulp_cmd_type'(dinS);
  wire logic        lowPwr = (state_ff == ST_LOWPWR);
  wire logic        clkRun = pllLocked && !lowPwr;
  wire logic [7:0]  rxCmd  = `ULP_RXCMD_ACT | {6'h00, lsS};
  wire logic        otgChg = (otgS != otgPrev_ff);
  wire logic [7:0]  lpData = {4'h0, lpInt_ff, 1'b0, lsS};
  wire logic        suspM  = funcCtl[`ULP_FUNC_SUSPM];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinsMeta_ff <= '0;
      pinsSync_ff <= '0;
    end
    else
    begin
      pinsMeta_ff <= {busStopIn, busDataIn, lineState, otgSense};
      pinsSync_ff <= pinsMeta_ff;
    end
  end

  ulp_clk_div #(
    .HALF (CLK_HALF)
  ) u_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .run      (clkRun),
    .phy_clock_output   (linkClk),
    .riseTick (linkTick)
  );

  ulp_reg_array u_regs (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .op         (op_ff),
    .suspendSet (suspSet),
    .otgSense   (otgS),
    .lineState  (lsS),
    .rdData     (rdData),
    .funcCtl    (funcCtl),
    .ifaceCtl   (ifaceCtl),
    .otgCtl     (otgCtl),
    .xcvrReset  (xcvrReset)
  );

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_dir     = busDir_ff;
    nxt_next    = busNext_ff;
    nxt_dout    = busDataOut_ff;
    nxt_oe      = busDataOe_ff;
    nxt_txData  = txData_ff;
    nxt_txValid = 1'b0;
    nxt_txLast  = 1'b0;
    nxt_rxTake  = 1'b0;
    nxt_op      = '0;
    nxt_addr    = addr_ff;
    nxt_wdata   = wdata_ff;
    suspSet     = 1'b0;
    if (lowPwr)
    begin
      nxt_oe   = 1'b1;
      nxt_dout = lpData;
      if (stpS)
      begin
        // Wake request: release the bus, restart the clock
        nxt_state = ST_START;
        nxt_oe    = 1'b0;
        suspSet   = 1'b1;
      end
    end
    else if (linkTick)
    begin
      case (state_ff)
        ST_START:
        begin
          nxt_dir   = 1'b0;
          nxt_state = ST_TURNBACK;
        end
        ST_IDLE:
        begin
          nxt_next = 1'b0;
          if (rxActive)
          begin
            nxt_dir   = 1'b1;
            nxt_state = ST_RXTURN;
          end
          else if (!suspM)
          begin
            nxt_dir   = 1'b1;
            nxt_state = ST_LOWPWR;
          end
          else if (cmd != 8'h00)
          begin
            nxt_addr = cmd.addr;
            case (cmd.kind)
              `ULP_CMD_TX:
              begin
                nxt_next  = 1'b1;
                nxt_state = ST_TXD;
              end
              `ULP_CMD_REGWR:
              begin
                nxt_next  = 1'b1;
                nxt_state = ST_WRCMD;
              end
              `ULP_CMD_REGRD:
              begin
                nxt_next  = 1'b1;
                nxt_state = ST_RDCMD;
              end
              default:
                nxt_next = 1'b0;
            endcase
          end
        end
        ST_TXD:
        begin
          if (stpS)
          begin
            nxt_next   = 1'b0;
            nxt_txLast = 1'b1;
            nxt_state  = ST_IDLE;
          end
          else
          begin
            if (busNext_ff)
            begin
              nxt_txValid = 1'b1;
              nxt_txData  = dinS;
            end
            nxt_next = txReady;
          end
        end
        ST_WRCMD:
        begin
          nxt_state = ST_WRDATA;
        end
        ST_WRDATA:
        begin
          nxt_wdata = dinS;
          nxt_next  = 1'b0;
          nxt_state = ST_WRSTOP;
        end
        ST_WRSTOP:
        begin
          if (stpS)
          begin
            nxt_op    = '{wr: 1'b1, rd: 1'b0, addr: addr_ff, data: wdata_ff};
            nxt_state = ST_IDLE;
          end
        end
        ST_RDCMD:
        begin
          nxt_next  = 1'b0;
          nxt_dir   = 1'b1;
          nxt_op    = '{wr: 1'b0, rd: 1'b1, addr: addr_ff, data: 8'h00};
          nxt_state = ST_RDTURN;
        end
        ST_RDTURN:
        begin
          nxt_oe    = 1'b1;
          nxt_dout  = rdData;
          nxt_state = ST_RDDATA;
        end
        ST_RDDATA:
        begin
          nxt_dir   = 1'b0;
          nxt_oe    = 1'b0;
          nxt_state = ST_TURNBACK;
        end
        ST_RXTURN:
        begin
          nxt_oe    = 1'b1;
          nxt_dout  = rxCmd;
          nxt_state = ST_RXDATA;
        end
        ST_RXDATA:
        begin
          if (!rxActive)
          begin
            nxt_dir   = 1'b0;
            nxt_oe    = 1'b0;
            nxt_next  = 1'b0;
            nxt_state = ST_TURNBACK;
          end
          else if (rxValid)
          begin
            nxt_dout   = rxData;
            nxt_next   = 1'b1;
            nxt_rxTake = 1'b1;
          end
          else
          begin
            nxt_dout = rxCmd;
            nxt_next = 1'b0;
          end
        end
        ST_TURNBACK:
        begin
          // Bus undefined here, nothing sampled
          nxt_state = ST_IDLE;
        end
        default:
          nxt_state = ST_START;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff      <= ST_START;
      busDir_ff     <= 1'b1;
      busNext_ff    <= 1'b0;
      busDataOut_ff <= 8'h00;
      busDataOe_ff  <= 1'b0;
      txData_ff     <= 8'h00;
      txValid_ff    <= 1'b0;
      txLast_ff     <= 1'b0;
      rxTake_ff     <= 1'b0;
      op_ff         <= '0;
      addr_ff       <= 6'h00;
      wdata_ff      <= 8'h00;
    end
    else
    begin
      state_ff      <= nxt_state;
      busDir_ff     <= nxt_dir;
      busNext_ff    <= nxt_next;
      busDataOut_ff <= nxt_dout;
      busDataOe_ff  <= nxt_oe && nxt_dir;
      txData_ff     <= nxt_txData;
      txValid_ff    <= nxt_txValid;
      txLast_ff     <= nxt_txLast;
      rxTake_ff     <= nxt_rxTake;
      op_ff         <= nxt_op;
      addr_ff       <= nxt_addr;
      wdata_ff      <= nxt_wdata;
    end
  end

  // Comparator change flag while suspended
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lpInt_ff   <= 1'b0;
      otgPrev_ff <= 5'h00;
    end
    else
    begin
      lpInt_ff   <= lowPwr && (lpInt_ff || otgChg);
      otgPrev_ff <= otgS;
    end
  end

  assign phyClockOutput = linkClk;
  assign busDir         = busDir_ff;
  assign busNext        = busNext_ff;
  assign busDataOut     = busDataOut_ff;
  assign busDataOe      = busDataOe_ff;
  assign txData         = txData_ff;
  assign txValid        = txValid_ff;
  assign txLast         = txLast_ff;
  assign rxTake         = rxTake_ff;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_dir_while_start: assert property ((state_ff == ST_START) |-> busDir_ff)
    else $error("direction low during start-up");
  a_drive_needs_dir: assert property (busDataOe_ff |-> busDir_ff)
    else $error("data driven while direction low");
  a_turnaround_gap: assert property ($changed(busDir_ff) |-> !busDataOe_ff)
    else $error("bus driven on direction change");
  a_rx_first_nonzero: assert property (($rose(busDataOe_ff) && state_ff == ST_RXDATA)
    |-> busDataOut_ff != 8'h00)
    else $error("transfer started with zero byte");
  a_next_takes_byte: assert property ((linkTick && state_ff == ST_TXD && busNext_ff && !stpS)
    |=> txValid_ff && txData_ff == $past(dinS))
    else $error("accepted byte not forwarded");
  a_stop_ends_tx: assert property ((linkTick && state_ff == ST_TXD && stpS)
    |=> txLast_ff && !txValid_ff && !busNext_ff && state_ff == ST_IDLE)
    else $error("stop did not end transmit");
  a_cmd_routed: assert property ((linkTick && state_ff == ST_IDLE && !rxActive && suspM
    && cmd.kind != `ULP_CMD_SPECIAL) |=> busNext_ff)
    else $error("command not acknowledged");
  a_turn_ignored: assert property ((state_ff == ST_TURNBACK) |-> !txValid_ff && !op_ff.wr)
    else $error("bus sampled in turn-around");
  a_lp_line_state: assert property ((lowPwr && $past(lowPwr) && busDataOe_ff)
    |-> busDataOut_ff[1:0] == $past(lsS) && !phyClockOutput)
    else $error("line state not shown in low power");
  a_lp_interrupt: assert property ((lowPwr && otgChg) |=> lowPwr |-> lpInt_ff ##1 (!lowPwr
    || busDataOut_ff[`ULP_LP_INT_BIT]))
    else $error("comparator change not flagged");
  a_rx_end_release: assert property ((linkTick && state_ff == ST_RXDATA && !rxActive)
    |=> !busDir_ff)
    else $error("bus held after receive end");
  a_rx_end_delay: assert property ((state_ff == ST_RXDATA && $fell(rxActive))
    |-> ##[1:RX_END_BUDGET] !busDir_ff)
    else $error("receive end delay too long");

endmodule

// ---- ulp_phy_port_tb.sv ----
/* Self-checking bench of the PHY link port with a link model on its bus.
   Assumes the package, the config header and the design files compile first. */
`timescale 1ns/1ns
`include "ulp_cfg.svh"
`define TB_CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin error_cnt++; \
  $display("Error %s exp %h got %h", nm, ex, sn); end end
module ulp_phy_port_tb;
  logic       ref_clk = 1'b0, rst_n = 1'b0, pllLocked = 1'b0;
  logic       txReady = 1'b1, rxActive = 1'b0, rxValid = 1'b0;
  logic [7:0] rxData    = 8'h00;
  logic [1:0] lineState = 2'h1;
  logic [4:0] otgSense  = 5'h00;
  logic       lclk, dir, nxt, stop, oe, txValid, txLast, rxTake, xRst;
  logic [7:0] busIn, busOut, txData, funcCtl, ifaceCtl, otgCtl, v;
  logic [7:0] txSeen[$];
  int         error_cnt, compares, lastCnt, xCnt, k;
  always #50 ref_clk = ~ref_clk;
  ulp_phy_port #(.CLK_HALF(4)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .phyClockOutput(lclk), .busDir(dir), .busNext(nxt),
    .busStopIn(stop), .busDataIn(busIn), .busDataOut(busOut), .busDataOe(oe),
    .txData(txData), .txValid(txValid), .txLast(txLast), .txReady(txReady),
    .rxActive(rxActive), .rxValid(rxValid), .rxData(rxData), .rxTake(rxTake),
    .pllLocked(pllLocked), .lineState(lineState), .otgSense(otgSense),
    .funcCtl(funcCtl), .ifaceCtl(ifaceCtl), .otgCtl(otgCtl), .xcvrReset(xRst));
  ulp_link_model i_link (
    .ref_clk(ref_clk), .lclk(lclk), .dir(dir), .nxt(nxt), .phyData(busOut), .phyOe(oe),
    .stopOut(stop), .bus(busIn));
  always @(posedge ref_clk)
  begin
    if (txValid === 1'b1)
      txSeen.push_back(txData);
    lastCnt <= lastCnt + int'(txLast === 1'b1);
    xCnt    <= xCnt + int'(xRst === 1'b1);
  end
  task automatic rd(input logic [5:0] a, input logic [7:0] ex);
    i_link.read(a, v);
    `TB_CHK("regRead", ex, v)
  endtask
  task automatic t_reset_values();
    // Identity bytes 5A C3 17 01 are arbitrary
    logic [13:0] tbl[11] = '{{6'h00, 8'h5A}, {6'h01, 8'hC3}, {6'h02, 8'h17}, {6'h03, 8'h01},
      {6'h04, 8'h41}, {6'h07, 8'h00}, {6'h0A, 8'h06}, {6'h0D, 8'h1F}, {6'h10, 8'h1F},
      {6'h14, 8'h00}, {6'h16, 8'h00}};
    repeat (40) @(negedge ref_clk);
    `TB_CHK("dirNoPll", 1'b1, dir)
    `TB_CHK("ctlPorts", 24'h410006, {funcCtl, ifaceCtl, otgCtl})
    pllLocked = 1'b1;
    foreach (tbl[i])
      rd(tbl[i][13:8], tbl[i][7:0]);
  endtask
  task automatic t_aliases();
    logic [5:0] bases[2] = '{6'h0A, 6'h16};
    foreach (bases[i])
    begin
      i_link.send('{{2'h2, bases[i]}, 8'h3C});
      i_link.send('{{2'h2, bases[i] + 6'h01}, 8'hC1});
      i_link.send('{{2'h2, bases[i] + 6'h02}, 8'h0F});
      for (k = 0; k < 3; k++)
        rd(bases[i] + 6'(k), 8'hF0);
    end
    `TB_CHK("otgCtl", 8'hF0, otgCtl)
    i_link.send('{8'h87, 8'hFF});
    rd(6'h07, 8'hFB);
    `TB_CHK("ifaceCtl", 8'hFB, ifaceCtl)
    i_link.send('{8'h89, 8'hFF});
  endtask
  task automatic t_xcvr_reset();
    k = xCnt;
    i_link.send('{8'h85, 8'h20});
    `TB_CHK("xcvrPulse", 1, xCnt - k)
    rd(6'h04, 8'h41);
    rd(6'h16, 8'hF0);
  endtask
  task automatic t_transmit();
    txSeen.delete();
    k = lastCnt;
    i_link.send('{8'h4A, 8'h12, 8'h34});
    `TB_CHK("txBytes", 24'h4A1234, {txSeen[0], txSeen[1], txSeen[2]})
    `TB_CHK("txCount", 3, txSeen.size())
    `TB_CHK("txLast", 1, lastCnt - k)
  endtask
  task automatic waitTake();
    k = 0;
    @(negedge ref_clk);
    while (rxTake !== 1'b1 && k++ < 100)
      @(negedge ref_clk);
  endtask
  task automatic t_receive();
    i_link.got.delete();
    rxData   = 8'h9C;
    rxValid  = 1'b1;
    rxActive = 1'b1;
    waitTake();
    rxData = 8'h27;
    waitTake();
    rxActive = 1'b0;
    rxValid  = 1'b0;
    i_link.own();
    `TB_CHK("rxStream", {`ULP_RXCMD_ACT | {6'h00, lineState}, 16'h9C27},
      {i_link.got[0], i_link.got[1], i_link.got[2]})
    `TB_CHK("rxCount", 3, i_link.got.size())
  endtask
  task automatic t_low_power();
    i_link.send('{8'h86, 8'h40});
    k = 0;
    while (oe !== 1'b1 && k++ < 100)
      @(negedge ref_clk);
    k = 0;
    repeat (32)
    begin
      @(negedge ref_clk);
      k += int'(lclk !== 1'b0);
    end
    `TB_CHK("clkStill", 0, k)
    `TB_CHK("lowPower", {3'b110, lineState}, {dir, oe, busOut[3], busOut[1:0]})
    otgSense  = 5'h04;
    lineState = 2'h2;
    repeat (8) @(negedge ref_clk);
    `TB_CHK("lowPowerIrq", 5'h1E, {dir, oe, busOut[3], busOut[1:0]})
    i_link.wake();
    rd(6'h04, 8'h41);
    rd(6'h13, 8'h04);
    rd(6'h14, 8'h04);
    rd(6'h14, 8'h00);
    rd(6'h15, 8'h02);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset_values();
    t_aliases();
    t_xcvr_reset();
    t_transmit();
    t_receive();
    t_low_power();
    final_report();
  end
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
endmodule

// ---- ulp_pkg.sv ----
/*
  Types of the PHY link port: state machine states, the command and pin
  layouts, and the packed carrier passed between the port logic and the register array.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ulp_pkg;

  typedef enum logic [3:0] {
    ST_START, ST_IDLE, ST_TXD, ST_WRCMD, ST_WRDATA, ST_WRSTOP, ST_RDCMD,
    ST_RDTURN, ST_RDDATA, ST_RXTURN, ST_RXDATA, ST_TURNBACK, ST_LOWPWR
  } ulp_state_type;

  typedef struct packed {
    logic [1:0] kind;
    logic [5:0] addr;
  } ulp_cmd_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] data;
  } ulp_regop_type;

  typedef struct packed {
    logic       stop;
    logic [7:0] data;
    logic [1:0] line;
    logic [4:0] otg;
  } ulp_pins_type;

endpackage

// ---- ulp_reg_array.sv ----
/*
  Eight-bit register array of the link port, 6-bit addressed, with
  write, set and clear aliases, interrupt edge latching and identity bytes.
  Assumes one access at a time from the port logic on ref_clk.
*/
`timescale 1ns/1ns
`include "ulp_cfg.svh"

module ulp_reg_array
  import ulp_pkg::*;
#(
  // Identity bytes: values are arbitrary
  parameter logic [7:0] MAKER_LO = 8'h5A,
  parameter logic [7:0] MAKER_HI = 8'hC3,
  parameter logic [7:0] PART_LO  = 8'h17,
  parameter logic [7:0] PART_HI  = 8'h01
)(
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // Access from the port logic
  input  wire ulp_regop_type op,
  input  wire logic          suspendSet,
  // Sensed levels
  input  wire logic [4:0]    otgSense,
  input  wire logic [1:0]    lineState,
  // Read data and control fields
  output logic [7:0]         rdData,
  output logic [7:0]         funcCtl,
  output logic [7:0]         ifaceCtl,
  output logic [7:0]         otgCtl,
  output logic               xcvrReset
);

  localparam int NRW = 6;
  localparam logic [NRW-1:0][5:0] BASE = {`ULP_AD_SCRATCH, `ULP_AD_IEF,
    `ULP_AD_IER, `ULP_AD_OTG, `ULP_AD_IFACE, `ULP_AD_FUNC};
  localparam logic [NRW-1:0][7:0] RST = {`ULP_RST_SCRATCH, `ULP_RST_IEF,
    `ULP_RST_IER, `ULP_RST_OTG, `ULP_RST_IFACE, `ULP_RST_FUNC};
  localparam logic [NRW-1:0][7:0] KEEP = {`ULP_KEEP_ALL, `ULP_KEEP_ALL,
    `ULP_KEEP_ALL, `ULP_KEEP_ALL, `ULP_KEEP_IFACE, `ULP_KEEP_FUNC};
  localparam logic [7:0] XRST = 8'h01 << `ULP_FUNC_XRST;
  localparam logic [7:0] SUSP = 8'h01 << `ULP_FUNC_SUSPM;
  localparam logic [3:0][7:0] IDS = {PART_HI, PART_LO, MAKER_HI, MAKER_LO};

  logic [NRW-1:0][7:0] rw_ff;
  logic [NRW-1:0][7:0] rdPart;
  logic [7:0]          rdRw;
  logic [4:0]          prev_ff;
  logic [4:0]          latch_ff;
  logic [7:0]          rdData_ff;
  logic                xrst_ff;

  for (genvar i = 0; i < NRW; i++)
  begin : g_rw
    wire logic [5:0] off = op.addr - BASE[i];
    wire logic inRange = (op.addr >= BASE[i]) && (off < `ULP_ALIAS_CNT);
    wire logic [7:0] upd = (off == 6'h00) ? op.data :
                           (off == 6'h01) ? (rw_ff[i] | op.data) :
                           (rw_ff[i] & ~op.data);
    wire logic [7:0] nxt_rw = (op.wr && inRange) ? (upd & KEEP[i]) : rw_ff[i];
    assign rdPart[i] = inRange ? rw_ff[i] : 8'h00;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        rw_ff[i] <= RST[i];
      else if (i == 0)
        rw_ff[i] <= (nxt_rw & ~XRST) | (suspendSet ? SUSP : 8'h00);
      else
        rw_ff[i] <= nxt_rw;
    end
  end

  always_comb
  begin
    rdRw = 8'h00;
    for (int i = 0; i < NRW; i++)
      rdRw = rdRw | rdPart[i];
  end

  wire logic       xrstHit   = op.wr && g_rw[0].inRange && g_rw[0].upd[`ULP_FUNC_XRST];
  wire logic       latchRead = op.rd && (op.addr == `ULP_AD_LATCH);
  wire logic [4:0] edges     = (otgSense & ~prev_ff & rw_ff[3][4:0]) |
                               (~otgSense & prev_ff & rw_ff[4][4:0]);
  wire logic [4:0] nxt_latch = (latchRead ? 5'h00 : latch_ff) | edges;
  // Unlisted addresses read zero
  wire logic [7:0] rdMux = (op.addr < `ULP_AD_ID_END) ? IDS[op.addr[1:0]] :
                           (op.addr == `ULP_AD_STAT) ? {3'h0, otgSense} :
                           (op.addr == `ULP_AD_LATCH) ? {3'h0, latch_ff} :
                           (op.addr == `ULP_AD_DEBUG) ? {6'h00, lineState} :
                           rdRw;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_ff   <= 5'h00;
      latch_ff  <= 5'h00;
      rdData_ff <= 8'h00;
      xrst_ff   <= 1'b0;
    end
    else
    begin
      prev_ff   <= otgSense;
      latch_ff  <= nxt_latch;
      rdData_ff <= op.rd ? rdMux : rdData_ff;
      xrst_ff   <= xrstHit;
    end
  end

  assign rdData    = rdData_ff;
  assign funcCtl   = rw_ff[0];
  assign ifaceCtl  = rw_ff[1];
  assign otgCtl    = rw_ff[2];
  assign xcvrReset = xrst_ff;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_xrst_self_clear: assert property (xcvrReset |-> !funcCtl[`ULP_FUNC_XRST])
    else $error("transceiver reset bit not cleared");
  a_set_alias_or: assert property ((op.wr && op.addr == `ULP_AD_SCRATCH + 6'h01)
    |=> rw_ff[5] == ($past(rw_ff[5]) | $past(op.data)))
    else $error("set alias did not OR into register");

endmodule
